// [spc_defines.svh]
// Offsets, field positions, reset values and response codes of the SPI port.
// Assumes a 32-bit AXI4-Lite register bus with one word per register.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_OFS_DATA 4'h0
`define SPC_OFS_CTRL 4'h4
`define SPC_OFS_STAT 4'h8
`define SPC_BIT_IRQ_EN 7
`define SPC_BIT_PORT_EN 6
`define SPC_BIT_RATE_DIV 5
`define SPC_BIT_MASTER 4
`define SPC_BIT_CLOCK_POLARITY_BIT 3
`define SPC_BIT_CLOCK_PHASE_BIT 2
`define SPC_BIT_DONE 7
`define SPC_BIT_WCOL 6
`define SPC_BIT_OVR 5
`define SPC_BIT_MODE_FAULT_FLAG 4
`define SPC_BIT_SOD 2
`define SPC_BIT_SSM 1
`define SPC_BIT_SSI 0
`define SPC_CTRL_RESET 8'h00
`define SPC_STAT_RESET 8'h00
`define SPC_RESP_OKAY 2'b00
`define SPC_RESP_SLVERR 2'b10
`endif

// [spc_pkg.sv]
// Types shared by the SPI port.
// Assumes spc_defines.svh is included by the users of its constants.
package spc_pkg;
    typedef enum logic [2:0] {
        SPC_IDLE = 3'b001,
        SPC_SHIFT = 3'b010,
        SPC_DONE = 3'b100
    } spc_state_type;
endpackage : spc_pkg

// [spc_port.sv]
// SPI master/slave port with control, status and data registers.
// Assumes an AXI4-Lite master, synchronous pins and a CPU halt/wait input.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "spc_defines.svh"
module spc_port
    import spc_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // CPU power state and mask
    input wire logic cpu_halt_i,
    input wire logic cpu_irq_mask_i,
    // SPI pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic ss_n_i,
    // Alternate function select and requests
    output logic alt_func_o,
    output logic irq_o,
    output logic wake_o
);
    // ****************************************
    // Registers and state
    // ****************************************
    logic [7:0] spi_control;
    logic done_flag;
    logic wcol_flag;
    logic ovr_flag;
    logic mode_fault_flag_flag;
    logic [2:0] soft_bits;
    logic [DATA_W-1:0] shifter;
    logic [DATA_W-1:0] rx_buf;
    logic [6:0] div_cnt;
    logic [3:0] edge_cnt;
    logic sck_int;
    logic sck_prev;
    logic status_seen;
    logic mode_fault_flag_seen;
    spc_state_type state;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic [3:0] ar_addr;
    logic ar_pend;
    logic halt_sel_ok;

    // ****************************************
    // Decoded control
    // ****************************************
    logic port_en;
    logic master;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic ss_int_n;
    logic run;
    logic do_write;
    logic do_read;
    logic [6:0] half_div;
    logic sl_edge;
    logic sl_lead;
    logic xfer_end;
    logic [2:0] rate;
    assign port_en = spi_control[`SPC_BIT_PORT_EN];
    assign master = spi_control[`SPC_BIT_MASTER];
    assign clock_polarity_bit = spi_control[`SPC_BIT_CLOCK_POLARITY_BIT];
    assign clock_phase_bit = spi_control[`SPC_BIT_CLOCK_PHASE_BIT];
    // Software select replaces the pin when management bit set
    assign ss_int_n = soft_bits[`SPC_BIT_SSM] ? soft_bits[`SPC_BIT_SSI]
                                              : ss_n_i;
    // Halt freezes control, flags and shift engine, but a selected slave keeps shifting
    assign run = enable_i && (!cpu_halt_i || (!master && halt_sel_ok));
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;
    assign do_read = ar_pend && !s_axi_rvalid_o;
    assign rate = {spi_control[`SPC_BIT_RATE_DIV], spi_control[1:0]};
    // Half period of SCK in clocks, less one; rate bits only matter as master
    always_comb
    begin
        unique case (rate)
            3'b100: half_div = 7'h01;
            3'b000: half_div = 7'h03;
            3'b001: half_div = 7'h07;
            3'b110: half_div = 7'h0f;
            3'b010: half_div = 7'h1f;
            3'b011: half_div = 7'h3f;
            default: half_div = 7'h03;
        endcase
    end
    // Slave samples sck edges against the previous sample
    assign sl_edge = !master && port_en && !ss_int_n && (sck_i != sck_prev);
    // Leading edge goes away from idle level; capture edge per phase
    assign sl_lead = (sck_i != clock_polarity_bit);
    assign xfer_end = (state == SPC_SHIFT) && (edge_cnt == 4'hf) &&
                      (master ? (div_cnt == 7'h00) : sl_edge);

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are taken in either order, one write outstanding
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SPC_RESP_OKAY;
        end
        else if (enable_i)
        begin
            if (s_axi_awvalid_i && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_held)
            begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata_i[7:0];
                w_lane <= s_axi_wstrb_i[0];
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr == `SPC_OFS_DATA ||
                                  aw_addr == `SPC_OFS_CTRL ||
                                  aw_addr == `SPC_OFS_STAT) ?
                                 `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end
    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o = !w_held;

    // Read port; returns live register state
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            ar_pend <= 1'b0;
            ar_addr <= 4'h0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `SPC_RESP_OKAY;
        end
        else if (enable_i)
        begin
            if (s_axi_arvalid_i && !ar_pend)
            begin
                ar_pend <= 1'b1;
                ar_addr <= s_axi_araddr_i;
            end
            if (do_read)
            begin
                ar_pend <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= `SPC_RESP_OKAY;
                unique case (ar_addr)
                    `SPC_OFS_DATA: s_axi_rdata_o <= {24'h0, rx_buf};
                    `SPC_OFS_CTRL: s_axi_rdata_o <= {24'h0, spi_control};
                    `SPC_OFS_STAT: s_axi_rdata_o <= {24'h0, done_flag,
                        wcol_flag, ovr_flag, mode_fault_flag_flag, 1'b0, soft_bits};
                    default:
                    begin
                        s_axi_rdata_o <= 32'h0;
                        s_axi_rresp_o <= `SPC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end
    assign s_axi_arready_o = !ar_pend;

    // ****************************************
    // Control and status registers
    // ****************************************
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic rd_stat;
    logic rd_data;
    assign wr_ctrl = do_write && w_lane && aw_addr == `SPC_OFS_CTRL;
    assign wr_stat = do_write && w_lane && aw_addr == `SPC_OFS_STAT;
    assign wr_data = do_write && w_lane && aw_addr == `SPC_OFS_DATA;
    assign rd_stat = do_read && ar_addr == `SPC_OFS_STAT;
    assign rd_data = do_read && ar_addr == `SPC_OFS_DATA;

    // Control register; fault hardware clear beats the software write
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            spi_control <= `SPC_CTRL_RESET;
        else if (run)
        begin
            if (master && port_en && !ss_int_n)
            begin
                spi_control[`SPC_BIT_PORT_EN] <= 1'b0;
                spi_control[`SPC_BIT_MASTER] <= 1'b0;
            end
            else if (wr_ctrl)
            begin
                spi_control <= w_byte;
                // Enable and master stay blocked unless clearing the fault
                if (mode_fault_flag_flag && !mode_fault_flag_seen)
                    spi_control[6:4] <= {1'b0, w_byte[5], 1'b0};
            end
        end
    end

    // Software management bits of the status register
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            soft_bits <= 3'h0;
        else if (run && wr_stat)
            soft_bits <= w_byte[2:0];
    end

    // Flags: a hardware set always wins over a same-cycle clear
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            done_flag <= 1'b0;
            ovr_flag <= 1'b0;
            mode_fault_flag_flag <= 1'b0;
            wcol_flag <= 1'b0;
            status_seen <= 1'b0;
            mode_fault_flag_seen <= 1'b0;
        end
        else if (run)
        begin
            if (rd_stat && done_flag)
                status_seen <= 1'b1;
            if (rd_stat && mode_fault_flag_flag)
                mode_fault_flag_seen <= 1'b1;
            if (xfer_end)
                done_flag <= 1'b1;
            else if (status_seen && (rd_data || wr_data))
            begin
                done_flag <= 1'b0;
                status_seen <= 1'b0;
            end
            if (xfer_end && done_flag)
                ovr_flag <= 1'b1;
            else if (rd_stat)
                ovr_flag <= 1'b0;
            if (master && port_en && !ss_int_n)
                mode_fault_flag_flag <= 1'b1;
            else if (mode_fault_flag_seen && wr_ctrl)
            begin
                mode_fault_flag_flag <= 1'b0;
                mode_fault_flag_seen <= 1'b0;
            end
            if (wr_data && state == SPC_SHIFT)
                wcol_flag <= 1'b1;
            else if (rd_stat && wcol_flag)
                wcol_flag <= 1'b0;
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    // Data write loads the shifter; blocked mid-transfer or while done flag set and status unread
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            state <= SPC_IDLE;
            shifter <= '0;
            rx_buf <= '0;
            div_cnt <= 7'h00;
            edge_cnt <= 4'h0;
            sck_int <= 1'b0;
            sck_prev <= 1'b0;
        end
        else if (run)
        begin
            sck_prev <= sck_i;
            unique case (state)
                SPC_IDLE:
                begin
                    sck_int <= clock_polarity_bit;
                    edge_cnt <= 4'h0;
                    div_cnt <= half_div;
                    if (wr_data && !(done_flag && !status_seen))
                    begin
                        shifter <= w_byte;
                        if (master && port_en)
                            state <= SPC_SHIFT;
                    end
                    if (sl_edge && !master)
                    begin
                        state <= SPC_SHIFT;
                        // First slave edge counts too, or the byte ends short
                        edge_cnt <= 4'h1;
                        if (sl_lead != clock_phase_bit)
                            shifter <= {shifter[DATA_W-2:0], mosi_i};
                    end
                    if (!port_en)
                        state <= SPC_IDLE;
                end
                SPC_SHIFT:
                begin
                    if (master)
                    begin
                        if (div_cnt == 7'h00)
                        begin
                            div_cnt <= half_div;
                            sck_int <= !sck_int;
                            edge_cnt <= edge_cnt + 4'h1;
                            // Odd count means second half of bit
                            if (edge_cnt[0] == clock_phase_bit)
                                shifter <= {shifter[DATA_W-2:0], miso_i};
                        end
                        else
                            div_cnt <= div_cnt - 7'h01;
                    end
                    else if (sl_edge)
                    begin
                        edge_cnt <= edge_cnt + 4'h1;
                        if (sl_lead != clock_phase_bit)
                            shifter <= {shifter[DATA_W-2:0], mosi_i};
                    end
                    if (xfer_end)
                        state <= SPC_DONE;
                    if (!port_en)
                        state <= SPC_IDLE;
                end
                SPC_DONE:
                begin
                    // Shifter keeps the received byte, so it echoes out
                    // On overrun the buffer keeps the earlier byte
                    if (!ovr_flag)
                        rx_buf <= shifter;
                    sck_int <= clock_polarity_bit;
                    state <= SPC_IDLE;
                end
            endcase
        end
    end

    // Latch selection at halt entry; wake needs it low
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            halt_sel_ok <= 1'b0;
        else if (enable_i && !cpu_halt_i)
            halt_sel_ok <= !ss_int_n;
    end

    // ****************************************
    // Pins and requests
    // ****************************************
    // Pin drivers; roles swap with master select
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            alt_func_o <= 1'b0;
            sck_o <= 1'b0;
            sck_oe_n_o <= 1'b1;
            mosi_o <= 1'b0;
            mosi_oe_n_o <= 1'b1;
            miso_o <= 1'b0;
            miso_oe_n_o <= 1'b1;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else if (enable_i)
        begin
            alt_func_o <= port_en;
            sck_o <= sck_int;
            sck_oe_n_o <= !(port_en && master);
            mosi_o <= shifter[DATA_W-1];
            mosi_oe_n_o <= !(port_en && master &&
                             !soft_bits[`SPC_BIT_SOD]);
            miso_o <= shifter[DATA_W-1];
            miso_oe_n_o <= !(port_en && !master && !ss_int_n &&
                             !soft_bits[`SPC_BIT_SOD]);
            // One shared request, gated by enable bit and CPU mask
            irq_o <= spi_control[`SPC_BIT_IRQ_EN] && !cpu_irq_mask_i &&
                     (done_flag || mode_fault_flag_flag || ovr_flag);
            // Done, fault or overrun wakes from wait; only done wakes from halt
            wake_o <= spi_control[`SPC_BIT_IRQ_EN] &&
                      (cpu_halt_i ? done_flag :
                       (done_flag || mode_fault_flag_flag || ovr_flag));
        end
    end
endmodule : spc_port

// [spc_port_props.sv]
// Concurrent checks on the pins and requests of the SPI port.
// Assumes a bind onto spc_port; it sees only that module's ports.
`timescale 1ns/10ps
module spc_port_props
#(
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // CPU state and select pin
    input wire logic cpu_halt_i,
    input wire logic cpu_irq_mask_i,
    input wire logic ss_n_i,
    // Pin drivers and requests
    input wire logic sck_o,
    input wire logic sck_oe_n_o,
    input wire logic mosi_oe_n_o,
    input wire logic miso_oe_n_o,
    input wire logic alt_func_o,
    input wire logic irq_o,
    input wire logic wake_o
);
    // ****************************
    // Pin and request properties
    // ****************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    // Reset keeps the port off its pins, so it cannot be masked by reset
    reset_clear_a: assert property (disable iff (1'b0)
        !reset_n_i |=> !alt_func_o && sck_oe_n_o && !irq_o && !wake_o)
        else $error("port not idle after reset");
    pins_free_a: assert property (
        !alt_func_o |-> sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o)
        else $error("pin driven while port disabled");
    master_pins_a: assert property (
        !sck_oe_n_o |-> !mosi_oe_n_o && miso_oe_n_o)
        else $error("master pin roles wrong");
    fault_drop_a: assert property (
        !ss_n_i && !sck_oe_n_o |-> ##[1:4] sck_oe_n_o)
        else $error("master kept SCK after select low");
    rate_spacing_a: assert property (
        $changed(sck_o) && !sck_oe_n_o |=> $stable(sck_o))
        else $error("SCK half period below two clocks");
    irq_mask_a: assert property (
        cpu_irq_mask_i |=> !irq_o)
        else $error("request raised while masked");
    irq_wake_a: assert property (
        irq_o && !$past(cpu_halt_i) |-> wake_o)
        else $error("request without wake outside halt");
    halt_freeze_a: assert property (
        (cpu_halt_i && !sck_oe_n_o)[*3] |-> $stable(sck_o))
        else $error("SCK moved in halt");
endmodule : spc_port_props

bind spc_port spc_port_props #(.DATA_W(DATA_W)) props_u (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .cpu_halt_i(cpu_halt_i),
    .cpu_irq_mask_i(cpu_irq_mask_i), .ss_n_i(ss_n_i), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .mosi_oe_n_o(mosi_oe_n_o),
    .miso_oe_n_o(miso_oe_n_o), .alt_func_o(alt_func_o), .irq_o(irq_o),
    .wake_o(wake_o)
);

// [spc_slave_model.sv]
// Behavioural SPI slave peer seen by the port in master mode.
// Assumes SCK edges come at least two bench clocks apart.
`timescale 1ns/10ps
module spc_slave_model
(
    // Clock
    input wire logic clock_i,
    // Pins and setup
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic clock_polarity_bit_i,
    input wire logic clock_phase_bit_i,
    input wire logic [7:0] tx_i,
    // Outputs
    output logic miso_o,
    output logic [7:0] rx_o
);
    // *****************
    // Shift behaviour
    // *****************
    logic s_q = 1'b0;
    logic junk = 1'b0;
    logic out_q = 1'b0;
    logic [7:0] sh = 8'h00;
    logic mosi_q = 1'b0;
    logic s;
    assign s = sck_i ^ clock_polarity_bit_i; // Same polarity as the master
    // Released line toggles so a stale bit can never pass
    assign miso_o = sel_n_i ? junk : out_q;
    // Capture on the chosen edge, launch on the other one; the falling
    // clock edge answers fast, and mosi_q holds the bit from before SCK moved
    always_ff @(negedge clock_i)
    begin
        s_q <= s;
        mosi_q <= mosi_i;
        junk <= ~junk;
        if (sel_n_i)
        begin
            sh <= tx_i;
            out_q <= tx_i[7];
        end
        else if (s != s_q)
        begin
            if (s ^ clock_phase_bit_i)
                rx_o <= {rx_o[6:0], mosi_q};
            else
            begin
                out_q <= clock_phase_bit_i ? sh[7] : sh[6];
                sh <= {sh[6:0], 1'b0};
            end
        end
    end
endmodule : spc_slave_model

// [spc_port_bench.sv]
// Self-checking bench: registers, master rates, slave wake and faults.
// Assumes the port, its checker and the slave model are compiled first.
`timescale 1ns/10ps
`include "spc_defines.svh"
module spc_port_bench
    import spc_pkg::*;
;
    // ***********************
    // Signals and bookkeeping
    // ***********************
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic arvalid = 1'b0, rready = 1'b1, halt = 1'b0, mask = 1'b0;
    logic ss_n = 1'b1, sel_n = 1'b1, sck_b = 1'b0, mosi_b = 1'b0;
    logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, armed = 1'b0, sck_q = 1'b0;
    logic [31:0] wdata = 32'h0, seed = 32'h0000_09d3;
    logic [7:0] tx_m = 8'h00, tx_s, ctl, echo, rd_last, m_rx;
    logic [34:0] note;
    logic [34:0] rq[$];
    int hq[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, cnt = 0;
    logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe_n;
    logic mosi_o, mosi_oe_n, miso_o, miso_oe_n, alt, irq, wake, m_miso;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sck_w, mosi_w, miso_w;
    logic [2:0] rate [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    int div [6] = '{4, 8, 16, 32, 64, 128};
    // Wire levels from the port's output enables
    assign sck_w = sck_oe_n ? sck_b : sck_o;
    assign mosi_w = mosi_oe_n ? mosi_b : mosi_o;
    assign miso_w = miso_oe_n ? m_miso : miso_o;
    // Clock source
    initial forever #2.5 clock_i = ~clock_i;

    spc_port dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .enable_i(1'b1), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .cpu_halt_i(halt), .cpu_irq_mask_i(mask),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n),
        .ss_n_i(ss_n), .alt_func_o(alt), .irq_o(irq), .wake_o(wake));
    spc_slave_model peer_u (.clock_i(clock_i), .sel_n_i(sel_n),
        .sck_i(sck_w), .mosi_i(mosi_w), .clock_polarity_bit_i(clock_polarity_bit), .clock_phase_bit_i(clock_phase_bit),
        .tx_i(tx_m), .miso_o(m_miso), .rx_o(m_rx));

    // **************
    // Helper tasks
    // **************
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    function automatic logic [34:0] ex(input logic [7:0] v,
                                       input logic [1:0] r = 2'h0);
        return {1'b1, r, 24'h0, v};
    endfunction : ex
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Write: both channels offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clock_i);
            ad = ad | awready;
            dd = dd | wready;
            if (ad) awvalid <= 1'b0;
            if (dd) wvalid <= 1'b0;
        end
        while (!(ad && dd));
        do @(posedge clock_i); while (!bvalid);
        chk({32'h0, bresp}, 34'h0);
    endtask : wr
    // Read: the note goes on the queue, the watcher compares it if flagged
    task automatic rd(input logic [3:0] a, input logic [34:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rq.push_back(e);
        do @(posedge clock_i); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock_i); while (!rvalid);
        rd_last = rdata[7:0];
    endtask : rd
    // Bench as external master, idle-low SCK, capture on the first edge
    task automatic spi_xfer(input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_b <= d[i];
            repeat (4) @(posedge clock_i);
            echo[i] = miso_w;
            sck_b <= 1'b1;
            repeat (4) @(posedge clock_i);
            sck_b <= 1'b0;
        end
        repeat (8) @(posedge clock_i);
    endtask : spi_xfer

    // Read watcher: pops the oldest note on each accepted read beat, compares it if flagged
    always @(posedge clock_i)
    begin
        if (rvalid && rready && rq.size() > 0)
        begin
            note = rq.pop_front();
            if (note[34]) chk({rresp, rdata}, note[33:0]);
        end
    end
    // SCK watcher and hang limit; first full half period is compared
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
        if (!sck_oe_n && sck_o !== sck_q)
        begin
            if (armed) chk(34'(cnt), 34'(hq.pop_front()));
            armed = hq.size() > 0;
            cnt = 1;
        end
        else cnt++;
        sck_q = sck_o;
    end

    // ***************
    // Main sequence
    // ***************
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rd(`SPC_OFS_CTRL, ex(`SPC_CTRL_RESET));
        rd(`SPC_OFS_STAT, ex(`SPC_STAT_RESET));
        rd(4'hc, ex(8'h00, `SPC_RESP_SLVERR));
        chk({33'h0, alt}, 34'h0);
        $display("reset test done");
        for (int i = 0; i < 6; i++)
        begin
            ctl = {2'h3, rate[i][2], 1'b1, i[0], i[1], rate[i][1:0]};
            clock_polarity_bit <= i[0];
            clock_phase_bit <= i[1];
            tx_m <= xs();
            wr(`SPC_OFS_CTRL, 8'h00);
            wr(`SPC_OFS_CTRL, ctl);
            rd(`SPC_OFS_CTRL, ex(ctl));
            sel_n <= 1'b0;
            chk({33'h0, sck_o}, {33'h0, ctl[3]});
            chk({33'h0, alt}, 34'h1);
            hq.push_back(div[i] / 2);
            tx_s = xs();
            wr(`SPC_OFS_DATA, tx_s);
            rd_last = 8'h00;
            for (int k = 0; k < 400 && !rd_last[7]; k++)
                rd(`SPC_OFS_STAT, 35'h0);
            @(posedge clock_i);
            chk({33'h0, irq}, 34'h1);
            chk({26'h0, m_rx}, {26'h0, tx_s});
            rd(`SPC_OFS_DATA, ex(tx_m));
            rd(`SPC_OFS_STAT, ex(8'h00));
            chk({33'h0, sck_o}, {33'h0, ctl[3]});
            sel_n <= 1'b1;
        end
        $display("master test done");
        wr(`SPC_OFS_CTRL, 8'he3);
        ss_n <= 1'b0;
        @(posedge clock_i);
        halt <= 1'b1;
        spi_xfer(8'h5a);
        chk({33'h0, wake}, 34'h1);
        halt <= 1'b0;
        spi_xfer(8'hc3);
        chk({26'h0, echo}, 34'h5a);
        rd(`SPC_OFS_STAT, ex(8'ha0));
        rd(`SPC_OFS_STAT, ex(8'h80));
        rd(`SPC_OFS_DATA, ex(8'h5a));
        rd(`SPC_OFS_STAT, ex(8'h00));
        ss_n <= 1'b1;
        $display("slave test done");
        wr(`SPC_OFS_CTRL, 8'hd0);
        halt <= 1'b1;
        repeat (4) @(posedge clock_i);
        halt <= 1'b0;
        mask <= 1'b1;
        ss_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        chk({33'h0, irq}, 34'h0);
        chk({33'h0, wake}, 34'h1);
        rd(`SPC_OFS_CTRL, ex(8'h80));
        rd(`SPC_OFS_STAT, ex(8'h10));
        ss_n <= 1'b1;
        mask <= 1'b0;
        wr(`SPC_OFS_CTRL, 8'h00);
        rd(`SPC_OFS_STAT, ex(8'h00));
        $display("fault test done");
        end_of_test();
    end
endmodule : spc_port_bench
